// ### src/clock_mode_defines.vh
// offsets, field positions, reset values and timing counts of the clock mode block
`ifndef CLOCK_MODE_DEFINES_VH
`define CLOCK_MODE_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_IDENT_LOW 12'h000
`define OFS_IDENT_HIGH 12'h004
`define OFS_SILICON_REVISION 12'h008
`define OFS_WRITE_LOCK 12'h00c
`define OFS_BLOCK_ENABLE 12'h010
`define OFS_FIRST_ANALOG_PLL_INPUT 12'h014
`define OFS_SECOND_ANALOG_PLL_INPUT 12'h018
`define OFS_MASTER_CLOCK_CTRL 12'h01c
`define OFS_FREQ_OFFSET 12'h020
`define OFS_FRAC_FBDIV1 12'h024
`define OFS_FRAC_FBDIV2 12'h028
`define OFS_OSC_TYPE_TIMER 12'h02c
`define OFS_NOMINAL_DENOM 12'h030
`define OFS_NOMINAL_INTEGER 12'h034
`define OFS_NOMINAL_ADJUST 12'h038
`define OFS_BANK_ROUTE 12'h03c
`define OFS_MODE_STATUS 12'h040

// ****************************************
// field positions
// ****************************************
`define BIT_INPUT_BLOCK_ENABLE 0
`define BIT_DIGITAL_PLL_ENABLE 1
`define BIT_LOCK 0
`define BIT_MASTER_SOURCE 0
`define BIT_DIVIDE_BY_3 1
`define SEL_TOP 2
`define IDX_LSB 3

// ****************************************
// input selector codes
// ****************************************
`define SEL_CRYSTAL 3'h0
`define SEL_INPUT_CLOCK 3'h1
`define SEL_OSC_PINS 3'h2
`define SEL_DIGITAL_PLL 3'h4

// ****************************************
// reset values (204.8 = 204 + 4/5 nominal)
// ****************************************
`define RST_BLOCK_ENABLE 2'h0
`define RST_APLL_INPUT 5'h00
`define RST_MASTER_CLOCK_CTRL 2'h0
`define RST_NOMINAL_DENOM 16'h0005
`define RST_NOMINAL_INTEGER 8'hcc
`define RST_NOMINAL_ADJUST 16'h0004
`define RST_OSC_TYPE_TIMER 8'h00

// ****************************************
// master clock divide ratios
// ****************************************
`define DIV_RATIO_LOW 2'h2
`define DIV_RATIO_HIGH 2'h3

`endif

// ### src/master_clock_divider.v
// divides second analog pll ticks by 2 or 3 into master clock ticks
`timescale 1ns/100ps
`include "clock_mode_defines.vh"
module master_clock_divider (
    input wire clock,
    input wire reset_n,
    input wire divide_by_3,
    input wire pll_tick,
    output wire master_tick
);
    reg [1:0] count_reg;
    wire [1:0] ratio;

    assign ratio = divide_by_3 ? `DIV_RATIO_HIGH : `DIV_RATIO_LOW; // R11
    assign master_tick = pll_tick && (count_reg >= ratio - 2'h1); // R11

    // count restarts on each output tick; a ratio change takes effect within one period
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 2'h0;
        end else if (pll_tick) begin
            if (master_tick) begin
                count_reg <= 2'h0;
            end else begin
                count_reg <= count_reg + 2'h1;
            end
        end
    end
endmodule // master_clock_divider

// ### src/pll_mode_decoder.v
// decodes top-level operating mode from selectors and enables
`timescale 1ns/100ps
`include "clock_mode_defines.vh"
module pll_mode_decoder (
    input wire [2:0] first_select,
    input wire [2:0] second_select,
    input wire input_block_enable,
    input wire digital_pll_enable,
    output wire analog_only_mode,
    output wire combined_mode
);
    // analog-only mode holds only while the selector top bit is clear on both analog plls
    assign analog_only_mode = !first_select[`SEL_TOP] && !second_select[`SEL_TOP]; // R05
    assign combined_mode = (first_select == `SEL_DIGITAL_PLL) && input_block_enable
        && digital_pll_enable; // R08
endmodule // pll_mode_decoder

// ### src/clock_mode_master_clock_select.v
// top-level clock mode and master clock select with apb register file
//
// Overview of operation
// R01: a 16-bit read-only identification value is split over ident_low_reg and ident_high_reg.
// R02: silicon_revision_reg reads back a revision value for software to interpret.
// R03: while write_lock_reg is locked, writes to the configuration registers are ignored.
// R04: clearing input_block_enable or digital_pll_enable powers down that block.
// R05: the device is in analog-pll-only mode while every input selector has its top bit clear.
// R06: analog-only mode offers no activity or frequency monitoring and no hitless switching.
// R07: in analog-only mode each analog pll may take the crystal or any of four input clocks.
// R08: combined mode is first selector 100 with input block and digital pll both enabled.
// R09: master_clock_source_select at 1 routes the oscillator pins straight to the master clock.
// R10: master_clock_source_select at 0 takes the divided second analog pll output.
// R11: the master clock divider divides the second analog pll output by 2 or 3.
// R12: software keeps the second analog pll at 380-416.667 MHz or 570-625 MHz in that case.
// R13: software keeps the delivered master clock between 190 MHz and 208.333 MHz.
// R14: the second analog pll output may go to any of four output banks, also while dividing.
// R15: combined mode applies the frequency offset; analog-only mode uses feedback dividers.
// R16: software programs the oscillator timer for the type of local oscillator in use.
// R17: nominal master clock registers reset to 204.8 MHz and software reprograms them.
`timescale 1ns/100ps
`include "clock_mode_defines.vh"
module clock_mode_master_clock_select #(
    parameter [15:0] IDENT_VALUE = 16'h5a31,   // arbitrary identification value
    parameter [7:0] REVISION_VALUE = 8'h01,    // arbitrary revision value
    parameter OFFSET_WIDTH = 16
) (
    input wire clock,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire crystal_tick,
    input wire [3:0] input_clock_tick,
    input wire external_osc_pins_tick,
    input wire digital_pll_tick,
    input wire second_analog_pll_tick,
    output reg first_analog_pll_ref_tick,
    output reg second_analog_pll_ref_tick,
    output reg master_clock_tick,
    output reg input_block_power_down,
    output reg digital_pll_power_down,
    output reg analog_only_status,
    output reg combined_status,
    output reg monitoring_enable,
    output reg hitless_switch_enable,
    output reg [3:0] bank_from_second_pll,
    output reg [OFFSET_WIDTH-1:0] applied_freq_offset,
    output reg [31:0] first_feedback_divider,
    output reg [31:0] second_feedback_divider,
    output reg [7:0] oscillator_type_timer,
    output reg [15:0] nominal_clock_denominator,
    output reg [7:0] nominal_clock_integer,
    output reg [15:0] nominal_clock_adjust
);
    // ****************************************
    // register state
    // ****************************************
    reg write_lock_reg;
    reg input_block_enable;
    reg digital_pll_enable;
    reg [4:0] analog_pll_input_select_reg [0:1];
    reg master_clock_source_select;
    reg master_clock_divider_sel;
    reg [OFFSET_WIDTH-1:0] master_clock_freq_offset;
    reg [31:0] fractional_feedback_divider_reg [0:1];
    reg [7:0] oscillator_type_timer_reg;
    reg [15:0] nominal_denom_reg;
    reg [7:0] nominal_integer_reg;
    reg [15:0] nominal_adjust_reg;
    reg [3:0] bank_route_reg;

    wire analog_only_mode;
    wire combined_mode;
    wire divided_tick;
    wire setup_phase;
    wire write_commit;
    wire config_write;
    reg [31:0] read_next;
    reg mapped_next;
    reg [1:0] ref_tick_next;

    assign setup_phase = psel && !penable;
    // write lands at the access edge where the registered ready is seen high
    assign write_commit = psel && penable && pready && pwrite && !pslverr;
    assign config_write = write_commit && !write_lock_reg; // R03

    // ****************************************
    // mode decode and master clock divider
    // ****************************************
    pll_mode_decoder u_mode (
        .first_select(analog_pll_input_select_reg[0][2:0]),
        .second_select(analog_pll_input_select_reg[1][2:0]),
        .input_block_enable(input_block_enable),
        .digital_pll_enable(digital_pll_enable),
        .analog_only_mode(analog_only_mode),
        .combined_mode(combined_mode)
    );

    // divider keeps running in either source setting so switching back is glitch free
    master_clock_divider u_div (
        .clock(clock),
        .reset_n(reset_n),
        .divide_by_3(master_clock_divider_sel),
        .pll_tick(second_analog_pll_tick),
        .master_tick(divided_tick)
    );

    // ****************************************
    // apb slave: zero wait, answer in first access cycle
    // ****************************************
    always @* begin
        read_next = 32'h0000_0000;
        mapped_next = 1'b1;
        case (paddr)
            `OFS_IDENT_LOW: read_next = {24'h000000, IDENT_VALUE[7:0]}; // R01
            `OFS_IDENT_HIGH: read_next = {24'h000000, IDENT_VALUE[15:8]}; // R01
            `OFS_SILICON_REVISION: read_next = {24'h000000, REVISION_VALUE}; // R02
            `OFS_WRITE_LOCK: read_next = {31'h0, write_lock_reg};
            `OFS_BLOCK_ENABLE: read_next = {30'h0, digital_pll_enable, input_block_enable};
            `OFS_FIRST_ANALOG_PLL_INPUT: read_next = {27'h0, analog_pll_input_select_reg[0]};
            `OFS_SECOND_ANALOG_PLL_INPUT: read_next = {27'h0, analog_pll_input_select_reg[1]};
            `OFS_MASTER_CLOCK_CTRL: begin
                read_next = {30'h0, master_clock_divider_sel, master_clock_source_select};
            end
            `OFS_FREQ_OFFSET: read_next[OFFSET_WIDTH-1:0] = master_clock_freq_offset;
            `OFS_FRAC_FBDIV1: read_next = fractional_feedback_divider_reg[0];
            `OFS_FRAC_FBDIV2: read_next = fractional_feedback_divider_reg[1];
            `OFS_OSC_TYPE_TIMER: read_next = {24'h000000, oscillator_type_timer_reg};
            `OFS_NOMINAL_DENOM: read_next = {16'h0000, nominal_denom_reg};
            `OFS_NOMINAL_INTEGER: read_next = {24'h000000, nominal_integer_reg};
            `OFS_NOMINAL_ADJUST: read_next = {16'h0000, nominal_adjust_reg};
            `OFS_BANK_ROUTE: read_next = {28'h0000000, bank_route_reg};
            `OFS_MODE_STATUS: begin
                read_next = {28'h0000000, digital_pll_enable, input_block_enable,
                    combined_mode, analog_only_mode};
            end
            default: mapped_next = 1'b0;
        endcase
    end

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && !mapped_next;
            if (setup_phase && !pwrite) begin
                prdata <= read_next;
            end
        end
    end

    // ****************************************
    // register writes
    // ****************************************
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            write_lock_reg <= 1'b0;
            input_block_enable <= 1'b0;
            digital_pll_enable <= 1'b0;
            analog_pll_input_select_reg[0] <= `RST_APLL_INPUT;
            analog_pll_input_select_reg[1] <= `RST_APLL_INPUT;
            master_clock_source_select <= 1'b0;
            master_clock_divider_sel <= 1'b0;
            master_clock_freq_offset <= {OFFSET_WIDTH{1'b0}};
            fractional_feedback_divider_reg[0] <= 32'h0000_0000;
            fractional_feedback_divider_reg[1] <= 32'h0000_0000;
            oscillator_type_timer_reg <= `RST_OSC_TYPE_TIMER;
            nominal_denom_reg <= `RST_NOMINAL_DENOM; // R17
            nominal_integer_reg <= `RST_NOMINAL_INTEGER; // R17
            nominal_adjust_reg <= `RST_NOMINAL_ADJUST; // R17
            bank_route_reg <= 4'h0;
        end else begin
            // the lock register itself stays writable so software can unlock
            if (write_commit && paddr == `OFS_WRITE_LOCK) begin
                write_lock_reg <= pwdata[`BIT_LOCK]; // R03
            end
            if (config_write) begin // R03
                case (paddr)
                    `OFS_BLOCK_ENABLE: begin
                        input_block_enable <= pwdata[`BIT_INPUT_BLOCK_ENABLE]; // R04
                        digital_pll_enable <= pwdata[`BIT_DIGITAL_PLL_ENABLE]; // R04
                    end
                    `OFS_FIRST_ANALOG_PLL_INPUT: analog_pll_input_select_reg[0] <= pwdata[4:0];
                    `OFS_SECOND_ANALOG_PLL_INPUT: analog_pll_input_select_reg[1] <= pwdata[4:0];
                    `OFS_MASTER_CLOCK_CTRL: begin
                        master_clock_source_select <= pwdata[`BIT_MASTER_SOURCE];
                        master_clock_divider_sel <= pwdata[`BIT_DIVIDE_BY_3];
                    end
                    `OFS_FREQ_OFFSET: master_clock_freq_offset <= pwdata[OFFSET_WIDTH-1:0];
                    `OFS_FRAC_FBDIV1: fractional_feedback_divider_reg[0] <= pwdata; // R15
                    `OFS_FRAC_FBDIV2: fractional_feedback_divider_reg[1] <= pwdata; // R15
                    `OFS_OSC_TYPE_TIMER: oscillator_type_timer_reg <= pwdata[7:0]; // R16
                    `OFS_NOMINAL_DENOM: nominal_denom_reg <= pwdata[15:0]; // R17
                    `OFS_NOMINAL_INTEGER: nominal_integer_reg <= pwdata[7:0]; // R17
                    `OFS_NOMINAL_ADJUST: nominal_adjust_reg <= pwdata[15:0]; // R17
                    `OFS_BANK_ROUTE: bank_route_reg <= pwdata[3:0]; // R14
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************
    // analog pll reference muxes
    // ****************************************
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_ref
            always @* begin
                case (analog_pll_input_select_reg[p][2:0])
                    `SEL_CRYSTAL: ref_tick_next[p] = crystal_tick; // R07
                    `SEL_INPUT_CLOCK: begin
                        ref_tick_next[p] =
                            input_clock_tick[analog_pll_input_select_reg[p][4:3]]; // R07
                    end
                    `SEL_OSC_PINS: ref_tick_next[p] = external_osc_pins_tick;
                    // digital pll only feeds the analog pll when it is actually running
                    `SEL_DIGITAL_PLL: ref_tick_next[p] = digital_pll_tick && combined_mode;
                    default: ref_tick_next[p] = 1'b0;
                endcase
            end
        end
    endgenerate

    // ****************************************
    // registered outputs
    // ****************************************
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            first_analog_pll_ref_tick <= 1'b0;
            second_analog_pll_ref_tick <= 1'b0;
            master_clock_tick <= 1'b0;
            input_block_power_down <= 1'b1;
            digital_pll_power_down <= 1'b1;
            analog_only_status <= 1'b0;
            combined_status <= 1'b0;
            monitoring_enable <= 1'b0;
            hitless_switch_enable <= 1'b0;
            bank_from_second_pll <= 4'h0;
            applied_freq_offset <= {OFFSET_WIDTH{1'b0}};
            first_feedback_divider <= 32'h0000_0000;
            second_feedback_divider <= 32'h0000_0000;
            oscillator_type_timer <= `RST_OSC_TYPE_TIMER;
            nominal_clock_denominator <= `RST_NOMINAL_DENOM;
            nominal_clock_integer <= `RST_NOMINAL_INTEGER;
            nominal_clock_adjust <= `RST_NOMINAL_ADJUST;
        end else begin
            first_analog_pll_ref_tick <= ref_tick_next[0];
            second_analog_pll_ref_tick <= ref_tick_next[1];
            if (master_clock_source_select) begin
                master_clock_tick <= external_osc_pins_tick; // R09
            end else begin
                master_clock_tick <= divided_tick; // R10
            end
            input_block_power_down <= !input_block_enable; // R04
            digital_pll_power_down <= !digital_pll_enable; // R04
            analog_only_status <= analog_only_mode; // R05
            combined_status <= combined_mode; // R08
            monitoring_enable <= combined_mode && !analog_only_mode; // R06
            hitless_switch_enable <= combined_mode && !analog_only_mode; // R06
            bank_from_second_pll <= bank_route_reg; // R14
            if (combined_mode) begin
                applied_freq_offset <= master_clock_freq_offset; // R15
            end else begin
                applied_freq_offset <= {OFFSET_WIDTH{1'b0}}; // R15
            end
            first_feedback_divider <= fractional_feedback_divider_reg[0];
            second_feedback_divider <= fractional_feedback_divider_reg[1];
            oscillator_type_timer <= oscillator_type_timer_reg;
            nominal_clock_denominator <= nominal_denom_reg;
            nominal_clock_integer <= nominal_integer_reg;
            nominal_clock_adjust <= nominal_adjust_reg;
        end
    end
endmodule // clock_mode_master_clock_select

// ### tb/clock_mode_master_clock_select_chk.sv
// assertion checker for the clock mode and master clock select block
`timescale 1ns/100ps
module clock_mode_master_clock_select_chk #(
    parameter OFFSET_WIDTH = 16
) (
    input logic clock,
    input logic reset_n,
    input logic psel,
    input logic penable,
    input logic pready,
    input logic pslverr,
    input logic crystal_tick,
    input logic [3:0] input_clock_tick,
    input logic external_osc_pins_tick,
    input logic digital_pll_tick,
    input logic second_analog_pll_tick,
    input logic first_analog_pll_ref_tick,
    input logic master_clock_tick,
    input logic input_block_power_down,
    input logic digital_pll_power_down,
    input logic analog_only_status,
    input logic combined_status,
    input logic monitoring_enable,
    input logic hitless_switch_enable,
    input logic [OFFSET_WIDTH-1:0] applied_freq_offset
);
// ****************************************
// bus handshake and mode relations
// ****************************************
default clocking cb @(posedge clock); endclocking
default disable iff (!reset_n);
a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready stood two cycles");
a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
a_modes_apart: assert property (!(analog_only_status && combined_status))
    else $error("both modes at once");
a_combined_powered: assert property (
    combined_status |-> !input_block_power_down && !digital_pll_power_down)
    else $error("combined mode with a block powered down");
a_monitor_off: assert property (
    analog_only_status |-> !monitoring_enable && !hitless_switch_enable)
    else $error("monitoring active in analog-only mode");
a_monitor_on: assert property (
    combined_status |-> monitoring_enable && hitless_switch_enable)
    else $error("monitoring missing in combined mode");
a_offset_gated: assert property (!combined_status |-> applied_freq_offset == '0)
    else $error("offset applied outside combined mode");
// ****************************************
// tick paths
// ****************************************
a_ref_has_source: assert property (
    first_analog_pll_ref_tick |-> $past(crystal_tick || (|input_clock_tick)
    || external_osc_pins_tick || digital_pll_tick))
    else $error("reference tick without any source tick");
a_master_has_source: assert property (
    master_clock_tick |-> $past(external_osc_pins_tick || second_analog_pll_tick))
    else $error("master tick without a source tick");
endmodule // clock_mode_master_clock_select_chk

bind clock_mode_master_clock_select clock_mode_master_clock_select_chk #(
    .OFFSET_WIDTH(OFFSET_WIDTH)
) u_chk (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .crystal_tick(crystal_tick), .input_clock_tick(input_clock_tick),
    .external_osc_pins_tick(external_osc_pins_tick), .digital_pll_tick(digital_pll_tick),
    .second_analog_pll_tick(second_analog_pll_tick),
    .first_analog_pll_ref_tick(first_analog_pll_ref_tick),
    .master_clock_tick(master_clock_tick), .input_block_power_down(input_block_power_down),
    .digital_pll_power_down(digital_pll_power_down), .analog_only_status(analog_only_status),
    .combined_status(combined_status), .monitoring_enable(monitoring_enable),
    .hitless_switch_enable(hitless_switch_enable), .applied_freq_offset(applied_freq_offset)
);

// ### tb/tb_clock_mode_master_clock_select.sv
// self-checking testbench for the clock mode and master clock select block
`timescale 1ns/100ps
`include "clock_mode_defines.vh"
module tb_clock_mode_master_clock_select;
localparam [15:0] ID = 16'h3c96; // arbitrary identification value
localparam [7:0] SILICON_REVISION_REG = 8'h07; // arbitrary revision value
logic clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, q, fb1, fb2;
logic pready, pslverr, e, ref1, ref2, mtick, ib_pd, dp_pd, ao, cm, mon, hit;
logic crystal_tick = 1'b0, external_osc_pins_tick = 1'b0, digital_pll_tick = 1'b0;
logic second_analog_pll_tick = 1'b0;
logic [3:0] input_clock_tick = 4'h0, bank;
logic [15:0] ofs, den, adj;
logic [7:0] tmr, nint;
logic [31:0] mdl [0:16];
logic [11:0] mt [0:6] = '{12'hc04, 12'h404, 12'h804, 12'hc09, 12'hc82, 12'h005, 12'hc84};
integer err_count = 0, cmp_count = 0, seed = 97400, i, k, n;
always #50 clock = ~clock;
clock_mode_master_clock_select #(.IDENT_VALUE(ID), .REVISION_VALUE(SILICON_REVISION_REG))
    u_clock_mode_master_clock_select (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_tick(crystal_tick), .input_clock_tick(input_clock_tick),
    .external_osc_pins_tick(external_osc_pins_tick), .digital_pll_tick(digital_pll_tick),
    .second_analog_pll_tick(second_analog_pll_tick), .first_analog_pll_ref_tick(ref1),
    .second_analog_pll_ref_tick(ref2), .master_clock_tick(mtick), .input_block_power_down(ib_pd),
    .digital_pll_power_down(dp_pd), .analog_only_status(ao), .combined_status(cm),
    .monitoring_enable(mon), .hitless_switch_enable(hit), .bank_from_second_pll(bank),
    .applied_freq_offset(ofs), .first_feedback_divider(fb1), .second_feedback_divider(fb2),
    .oscillator_type_timer(tmr), .nominal_clock_denominator(den), .nominal_clock_integer(nint),
    .nominal_clock_adjust(adj));
// ****************************************
// reference model
// ****************************************
function automatic [31:0] msk(input integer r);
    case (r)
        3: msk = 32'h1;
        4, 7: msk = 32'h3;
        5, 6: msk = 32'h1f;
        8, 12, 14: msk = 32'hffff;
        9, 10: msk = 32'hffffffff;
        11, 13: msk = 32'hff;
        15: msk = 32'hf;
        default: msk = 32'h0;
    endcase
endfunction
function automatic logic ao_m();
    ao_m = !mdl[5][2] && !mdl[6][2];
endfunction
function automatic logic cm_m();
    cm_m = mdl[5][2:0] == 3'h4 && mdl[4][1:0] == 2'h3;
endfunction
function automatic [31:0] exp_rd(input integer r);
    case (r)
        0: exp_rd = {24'h0, ID[7:0]};
        1: exp_rd = {24'h0, ID[15:8]};
        2: exp_rd = {24'h0, SILICON_REVISION_REG};
        16: exp_rd = {28'h0, mdl[4][1], mdl[4][0], cm_m(), ao_m()};
        default: exp_rd = mdl[r];
    endcase
endfunction
task automatic mreset();
    for (int r = 0; r < 17; r++) mdl[r] = 32'h0;
    mdl[12] = `RST_NOMINAL_DENOM;
    mdl[13] = `RST_NOMINAL_INTEGER;
    mdl[14] = `RST_NOMINAL_ADJUST;
endtask
// ****************************************
// bus and compare tasks
// ****************************************
task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
        err_count++;
        $display("[ERR] %s expected %h seen %h", s, x, g);
    end
endtask
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    t = 0;
    do begin
        @(posedge clock);
        t++;
    end while (pready !== 1'b1 && t < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 50) chk("pready wait", 1, 0);
endtask
task automatic wr(input integer r, input logic [31:0] d);
    apb(1'b1, r * 4, d);
    chk("write error", 0, e);
    if (msk(r) != 0 && (!mdl[3][0] || r == 3)) mdl[r] = d & msk(r);
endtask
task automatic rd_all();
    for (int r = 0; r < 17; r++) begin
        apb(1'b0, r * 4, 32'h0);
        chk($sformatf("reg %0d", r), exp_rd(r), q);
    end
endtask
task automatic outs();
    repeat (2) @(posedge clock);
    chk("input block down", !mdl[4][0], ib_pd);
    chk("digital_pll down", !mdl[4][1], dp_pd);
    chk("analog only", ao_m(), ao);
    chk("combined", cm_m(), cm);
    chk("monitoring", cm_m(), mon);
    chk("hitless", cm_m(), hit);
    chk("offset", cm_m() ? mdl[8] : 0, ofs);
    chk("bank", mdl[15], bank);
    chk("fbdiv", {mdl[9], mdl[10]} === {fb1, fb2}, 1);
    chk("timer", mdl[11], tmr);
    chk("nominal", {mdl[12][15:0], mdl[13][7:0], mdl[14][15:0]} === {den, nint, adj}, 1);
endtask
task automatic pulse(input integer s, input logic x);
    @(posedge clock);
    case (s)
        0: crystal_tick <= 1'b1;
        5: external_osc_pins_tick <= 1'b1;
        6: digital_pll_tick <= 1'b1;
        default: input_clock_tick <= 4'h1 << (s - 1);
    endcase
    @(posedge clock);
    {crystal_tick, external_osc_pins_tick, digital_pll_tick, input_clock_tick} <= 7'h0;
    @(posedge clock);
    chk("ref ticks", {x, x}, {ref1, ref2});
    chk("master tick", s == 5, mtick);
endtask
task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
// ****************************************
// main sequence
// ****************************************
initial begin
    mreset();
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    rd_all();
    outs();
    for (i = 0; i < 3; i++) wr(i, $random(seed));
    wr(16, $random(seed));
    for (i = 4; i < 16; i++) wr(i, $random(seed));
    rd_all();
    outs();
    apb(1'b0, 12'h044, 32'h0);
    chk("unmapped read error", 1, e);
    chk("unmapped read data", 0, q);
    apb(1'b1, 12'hffc, $random(seed));
    chk("unmapped write", 1, e);
    for (i = 0; i < 7; i++) begin
        wr(5, mt[i][4:0]);
        wr(6, mt[i][9:5]);
        wr(4, mt[i][11:10]);
        outs();
    end
    wr(3, 32'h1);
    for (i = 4; i < 16; i++) wr(i, $random(seed));
    rd_all();
    outs();
    wr(3, 32'h0);
    wr(4, 32'h0);
    wr(7, 32'h1);
    // crystal, each input clock and the oscillator pins, then a tick that must not pass
    for (k = 0; k < 6; k++) begin
        n = (k == 0) ? 0 : (k == 5) ? 2 : (((k - 1) << 3) | 1);
        wr(5, n);
        wr(6, n);
        pulse(k, 1'b1);
        pulse((k + 1) % 7, 1'b0);
    end
    // digital pll reference passes only while combined mode holds
    wr(4, 32'h3);
    wr(5, 32'h4);
    wr(6, 32'h4);
    pulse(6, 1'b1);
    wr(4, 32'h1);
    pulse(6, 1'b0);
    // reset in mid-run, then count divided ticks with stray pin ticks
    for (k = 0; k < 2; k++) begin
        reset_n <= 1'b0;
        mreset();
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        outs();
        wr(7, k << 1);
        n = 0;
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            n = n + mtick;
            second_analog_pll_tick <= (i < 12);
            external_osc_pins_tick <= (i < 12);
        end
        chk("divided ticks", k ? 4 : 6, n);
    end
    stop_test();
end
initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    $display("[ERR] watchdog expected finish seen timeout");
    stop_test();
end
endmodule // tb_clock_mode_master_clock_select
